// ### rtl/mss_pkg.sv
// shared constants and carrier types of the motion sensor serial port
package mss_pkg;
    // serial register addresses
    localparam logic [6:0] MSS_A_MOTION = 7'h02;
    localparam logic [6:0] MSS_A_DX = 7'h03;
    localparam logic [6:0] MSS_A_DY = 7'h04;
    localparam logic [6:0] MSS_A_PEAK = 7'h08;
    localparam logic [6:0] MSS_A_BURST = 7'h42;
    localparam logic [2:0] MSS_BURST_LAST = 3'h6;
    localparam int MSS_DIR_BIT = 7;
    localparam int MSS_MOTION_BIT = 7;
    // local register port offsets and reset values
    localparam logic [3:0] MSS_L_CTRL = 4'h0;
    localparam logic [3:0] MSS_L_STATUS = 4'h1;
    localparam logic MSS_CTRL_RST = 1'b1;
    // timing
    localparam int MSS_CLK_HZ = 25_000_000;
    localparam int MSS_TICK_US = 100;
    localparam int MSS_TICK_CYCLES = MSS_CLK_HZ / 1_000_000 * MSS_TICK_US;
    localparam int MSS_REST1_DOWN_US = 237_000;
    localparam int MSS_REST2_DOWN_US = 8_400_000;
    localparam int MSS_REST3_DOWN_US = 504_000_000;
    localparam int MSS_RESP1_US = 16_500;
    localparam int MSS_RESP2_US = 82_000;
    localparam int MSS_RESP3_US = 410_000;
    localparam int MSS_REST1_DOWN_TICKS = MSS_REST1_DOWN_US / MSS_TICK_US;
    localparam int MSS_REST2_DOWN_TICKS = MSS_REST2_DOWN_US / MSS_TICK_US;
    localparam int MSS_REST3_DOWN_TICKS = MSS_REST3_DOWN_US / MSS_TICK_US;
    localparam int MSS_RESP1_TICKS = MSS_RESP1_US / MSS_TICK_US;
    localparam int MSS_RESP2_TICKS = MSS_RESP2_US / MSS_TICK_US;
    localparam int MSS_RESP3_TICKS = MSS_RESP3_US / MSS_TICK_US;
    localparam int MSS_RUN_TICKS = 1;

    typedef enum logic [1:0] {MSS_RUN, MSS_REST1, MSS_REST2, MSS_REST3} mss_mode_t;

    // serial pins as seen by the sensor
    typedef struct packed {
        logic port_select_low;
        logic sclk;
        logic mosi;
    } mss_pins_t;

    // one frame result from the image core
    typedef struct packed {
        logic [7:0] dx;
        logic [7:0] dy;
        logic [7:0] surface_quality;
        logic [15:0] shutter;
        logic [7:0] peak;
    } mss_frame_t;
endpackage

// ### rtl/mss_sync.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module mss_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= RST;
            q <= RST;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// ### rtl/mss_regfile.sv
// byte register store with registered read data
`timescale 1ns/1ns
`default_nettype none
module mss_regfile #(
    parameter int AW = 7
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    // no reset: contents are undefined until software writes them
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ### rtl/mss_port.sv
// serial slave port, motion pin and rest mode stepping of the motion sensor
//
// Behaviour
// - master starts transfers and supplies clock
// - select high: ignore inputs, output tristated
// - port enabled only after select low
// - select high aborts and resets port
// - burst ends only by raising select
// - write: address byte msb 1, data
// - input sampled on rising clock edges
// - read: address msb 0, sensor returns data
// - read data changes on falling edges
// - each output bit held until next fall
// - motion pin low while motion flag set
// - flag cleared by delta reads or write
// - three rest modes by idle time
// - each rest mode own polling period
// - laser flashed only per acquisition
// - burst returns seven motion bytes in order
// - burst may end after x displacement
// - motion 0x02, deltas 0x03 and 0x04
`timescale 1ns/1ns
`default_nettype none
module mss_port #(
    parameter int REST1_DOWN_TICKS = mss_pkg::MSS_REST1_DOWN_TICKS,
    parameter int REST2_DOWN_TICKS = mss_pkg::MSS_REST2_DOWN_TICKS,
    parameter int REST3_DOWN_TICKS = mss_pkg::MSS_REST3_DOWN_TICKS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire mss_pkg::mss_pins_t pins,
    output logic miso,
    output logic miso_oe,
    output logic motion_n,
    input wire mss_pkg::mss_frame_t frame,
    input wire logic frame_valid,
    output logic laser_flash,
    output mss_pkg::mss_mode_t power_mode,
    input wire logic [3:0] loc_addr,
    input wire logic [7:0] loc_wdata,
    input wire logic loc_wr,
    input wire logic loc_rd,
    output logic [7:0] loc_rdata
);
    import mss_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WDATA, ST_LOAD, ST_RDATA, ST_LOCK} mss_st_t;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and clock edge detection
    mss_pins_t s_pins;
    logic sclk_d;
    mss_sync #(.W(3), .RST(3'b110)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(pins),
        .q(s_pins)
    );
    wire logic s_ncs = s_pins.port_select_low;
    wire logic sclk_rise = s_pins.sclk & ~sclk_d;
    wire logic sclk_fall = ~s_pins.sclk & sclk_d;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) sclk_d <= 1'b1;
        else sclk_d <= s_pins.sclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // serial engine state
    mss_st_t state;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic [2:0] bit_cnt;
    logic burst;
    logic [2:0] burst_idx;
    logic load_wait;
    logic motion_flag;
    logic [7:0] dx_acc;
    logic [7:0] dy_acc;
    mss_frame_t last;
    logic [7:0] rf_rdata;

    // byte boundaries; address bits arrive msb first
    wire logic byte_done = sclk_rise && bit_cnt == 3'h7;
    wire logic [7:0] in_byte = {shreg[6:0], s_pins.mosi};
    wire logic load_go = state == ST_LOAD && load_wait;
    // burst walks the consecutive motion addresses
    wire logic [6:0] ld_addr = burst ? MSS_A_MOTION + {4'h0, burst_idx} : cmd[6:0];
    wire logic live = ld_addr >= MSS_A_MOTION && ld_addr <= MSS_A_PEAK;
    // motion flag sits in the top bit of the motion register
    wire logic [7:0] motion_byte = 8'(motion_flag) << MSS_MOTION_BIT;
    wire logic [7:0] live_byte =
        ld_addr == MSS_A_MOTION ? motion_byte :
        ld_addr == MSS_A_DX ? dx_acc :
        ld_addr == MSS_A_DY ? dy_acc :
        ld_addr == MSS_A_DY + 7'h1 ? last.surface_quality :
        ld_addr == MSS_A_DY + 7'h2 ? last.shutter[15:8] :
        ld_addr == MSS_A_DY + 7'h3 ? last.shutter[7:0] : last.peak;
    wire logic rd_dx = load_go && ld_addr == MSS_A_DX;
    wire logic rd_dy = load_go && ld_addr == MSS_A_DY;
    wire logic rf_we = state == ST_WDATA && byte_done && !s_ncs;
    wire logic motion_wr = rf_we && cmd[6:0] == MSS_A_MOTION;

    mss_regfile #(.AW(7)) u_rf (
        .clk(clk),
        .we(rf_we),
        .waddr(cmd[6:0]),
        .wdata(in_byte),
        .raddr(ld_addr),
        .rdata(rf_rdata)
    );

    // select high resets the engine state and counters at once; shreg, cmd and miso keep their values
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            burst <= 1'b0;
            burst_idx <= 3'h0;
            load_wait <= 1'b0;
        end else if (s_ncs) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            burst <= 1'b0;
            burst_idx <= 3'h0;
            load_wait <= 1'b0;
        end else begin
            if (sclk_rise) bit_cnt <= bit_cnt + 3'h1;
            load_wait <= state == ST_LOAD && !load_wait;
            case (state)
                ST_IDLE: state <= ST_ADDR;
                ST_ADDR: if (byte_done) begin
                    if (in_byte[MSS_DIR_BIT]) state <= ST_WDATA;
                    else state <= ST_LOAD;
                    burst <= in_byte[6:0] == MSS_A_BURST;
                end
                ST_WDATA: if (byte_done) state <= ST_ADDR;
                ST_LOAD: if (load_wait) state <= ST_RDATA;
                ST_RDATA: if (byte_done) begin
                    if (!burst) state <= ST_ADDR;
                    else if (burst_idx == MSS_BURST_LAST) state <= ST_LOCK;
                    else begin
                        burst_idx <= burst_idx + 3'h1;
                        state <= ST_LOAD;
                    end
                end
                ST_LOCK: state <= ST_LOCK;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // shifting: in on rising edges, out on falling edges
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shreg <= 8'h00;
            cmd <= 8'h00;
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end else if (s_ncs) begin
            miso_oe <= 1'b0;
        end else if (load_go) begin
            shreg <= live ? live_byte : rf_rdata;
            miso_oe <= 1'b1;
        end else if (state == ST_RDATA) begin
            if (sclk_fall) begin
                miso <= shreg[7];
                shreg <= {shreg[6:0], 1'b0};
            end
        end else if (sclk_rise && (state == ST_ADDR || state == ST_WDATA)) begin
            shreg <= in_byte;
            if (state == ST_ADDR && bit_cnt == 3'h7) cmd <= in_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // displacement accumulation and motion flag
    logic x_seen;
    logic y_seen;
    wire logic new_motion = frame_valid && (frame.dx != 8'h00 || frame.dy != 8'h00);
    wire logic both_read = (x_seen || rd_dx) && (y_seen || rd_dy);
    wire logic flag_clr = both_read || motion_wr;

    // a read clears the delta but a same-cycle frame still lands
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dx_acc <= 8'h00;
            dy_acc <= 8'h00;
            last <= '0;
        end else begin
            if (frame_valid) last <= frame;
            if (frame_valid) dx_acc <= (rd_dx ? 8'h00 : dx_acc) + frame.dx;
            else if (rd_dx) dx_acc <= 8'h00;
            if (frame_valid) dy_acc <= (rd_dy ? 8'h00 : dy_acc) + frame.dy;
            else if (rd_dy) dy_acc <= 8'h00;
        end
    end

    // set wins over clear so fresh motion is never lost
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            motion_flag <= 1'b0;
            x_seen <= 1'b0;
            y_seen <= 1'b0;
            motion_n <= 1'b1;
        end else begin
            if (new_motion) motion_flag <= 1'b1;
            else if (flag_clr) motion_flag <= 1'b0;
            // fresh motion re-arms both reads so a stale read cannot clear it
            x_seen <= !flag_clr && !new_motion && (x_seen || rd_dx);
            y_seen <= !flag_clr && !new_motion && (y_seen || rd_dy);
            motion_n <= !motion_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rest mode stepping and acquisition pacing
    logic ps_en;
    logic [11:0] prescale;
    logic [31:0] idle_ticks;
    logic [31:0] poll_cnt;
    wire logic tick = prescale == 12'(MSS_TICK_CYCLES - 1);
    wire mss_mode_t next_mode =
        !ps_en ? MSS_RUN :
        idle_ticks >= 32'(REST3_DOWN_TICKS) ? MSS_REST3 :
        idle_ticks >= 32'(REST2_DOWN_TICKS) ? MSS_REST2 :
        idle_ticks >= 32'(REST1_DOWN_TICKS) ? MSS_REST1 : MSS_RUN;
    wire logic [31:0] poll_period =
        power_mode == MSS_REST1 ? 32'(MSS_RESP1_TICKS) :
        power_mode == MSS_REST2 ? 32'(MSS_RESP2_TICKS) :
        power_mode == MSS_REST3 ? 32'(MSS_RESP3_TICKS) : 32'(MSS_RUN_TICKS);
    wire logic poll_due = tick && poll_cnt >= poll_period - 32'h1;

    // motion restarts the idle count and returns to full rate
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prescale <= 12'h000;
            idle_ticks <= 32'h0;
            poll_cnt <= 32'h0;
            power_mode <= MSS_RUN;
            laser_flash <= 1'b0;
        end else begin
            prescale <= tick ? 12'h000 : prescale + 12'h001;
            if (new_motion) idle_ticks <= 32'h0;
            else if (tick && idle_ticks != 32'hFFFF_FFFF) idle_ticks <= idle_ticks + 32'h1;
            power_mode <= new_motion ? MSS_RUN : next_mode;
            if (poll_due) poll_cnt <= 32'h0;
            else if (tick) poll_cnt <= poll_cnt + 32'h1;
            laser_flash <= poll_due;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // local register port: control and status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ps_en <= MSS_CTRL_RST;
            loc_rdata <= 8'h00;
        end else begin
            if (loc_wr && loc_addr == MSS_L_CTRL) ps_en <= loc_wdata[0];
            if (!loc_rd) loc_rdata <= 8'h00;
            else if (loc_addr == MSS_L_CTRL) loc_rdata <= {7'h00, ps_en};
            else if (loc_addr == MSS_L_STATUS) loc_rdata <= {5'h00, state == ST_LOCK, power_mode};
            else loc_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_load_pair;
        (state == ST_LOAD && !s_ncs) [*2];
    endsequence

    // a read of the burst address opens the sequence at the motion byte
    sequence s_burst_cmd;
        !s_ncs && state == ST_ADDR && byte_done && in_byte == {1'b0, MSS_A_BURST};
    endsequence

    idle_tristate_a: assert property (s_ncs |=> !miso_oe) else $error("miso driven while deselected");
    port_enable_a: assert property (miso_oe |-> $past(!s_ncs)) else $error("port active without select");
    abort_reset_a: assert property (s_ncs |=> state == ST_IDLE && bit_cnt == 3'h0) else $error("abort not reset");
    burst_lock_a: assert property (state == ST_LOCK && !s_ncs |=> state == ST_LOCK) else $error("burst lock left early");
    write_dir_a: assert property (rf_we |-> cmd[MSS_DIR_BIT] && state == ST_WDATA) else $error("write without direction bit");
    rise_sample_a: assert property (!s_ncs && state == ST_ADDR && !sclk_rise |=> $stable(bit_cnt)) else $error("sampled off rising edge");
    read_load_a: assert property (s_load_pair |=> state == ST_RDATA && miso_oe) else $error("read byte not loaded");
    miso_fall_a: assert property ($changed(miso) && $past(state == ST_RDATA) |-> $past(sclk_fall)) else $error("miso moved off fall");
    motion_low_a: assert property (motion_flag |=> !motion_n) else $error("motion pin not low");
    motion_clr_a: assert property (flag_clr && !new_motion |=> ##1 motion_n) else $error("motion pin not released");
    rest_step_a: assert property ($rose(power_mode == MSS_REST1) |-> idle_ticks >= 32'(REST1_DOWN_TICKS)) else $error("early rest");
    laser_pulse_a: assert property (laser_flash |=> !laser_flash) else $error("laser held on");
    burst_start_a: assert property (s_burst_cmd |=> burst && state == ST_LOAD && ld_addr == MSS_A_MOTION) else $error("burst not started at motion");
    dx_clear_a: assert property (rd_dx && !frame_valid |=> dx_acc == 8'h00) else $error("delta x kept after read");
endmodule
`default_nettype wire

// ### verif/mss_host.sv
// serial bus master model that drives the sensor port pins
`timescale 1ns/1ns
`default_nettype none
module mss_host (
    input wire logic clk,
    input wire logic miso_w,
    output mss_pkg::mss_pins_t pins
);
    import mss_pkg::*;
    // idle: deselected, clock parked high
    initial begin
        pins = 3'b110;
    end
    // select framing around each transaction
    task automatic sel(input logic on);
        @(posedge clk);
        pins.port_select_low <= ~on;
        repeat (8) @(posedge clk);
    endtask
    // up to 8 bits msb first; data set on fall, sampled late in the high phase
    task automatic xbyte(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            @(posedge clk);
            pins.sclk <= 1'b0;
            pins.mosi <= tx[i];
            repeat (4) @(posedge clk);
            pins.sclk <= 1'b1;
            repeat (3) @(posedge clk);
            rx[i] = miso_w;
        end
        // generous gap covers every inter-byte and inter-command delay
        repeat (16) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### verif/mss_port_tb.sv
// self-checking testbench of the motion sensor serial port
`timescale 1ns/1ns
`default_nettype none
module mss_port_tb;
    import mss_pkg::*;
    localparam int TK = MSS_TICK_CYCLES;
    typedef struct packed {logic [6:0] a; logic [7:0] d;} mss_row_t;
    logic clk;
    logic rst_b;
    logic flip = 1'b0;
    logic frame_valid;
    logic loc_wr;
    logic loc_rd;
    logic [3:0] loc_addr;
    logic [7:0] loc_wdata;
    logic miso, miso_oe, motion_n, laser_flash;
    logic [7:0] loc_rdata, r;
    mss_frame_t cur;
    mss_pins_t pins;
    mss_mode_t power_mode;
    wire logic miso_w;
    int failures = 0;
    int n_compared = 0;
    int flashes = 0;
    int f0;
    mss_row_t rows [4] = '{'{7'h10, 8'hA5}, '{7'h2E, 8'h5A}, '{7'h7F, 8'hFF}, '{7'h11, 8'h00}};
    logic [7:0] bexp [7] = '{8'h80, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    ////////////////////////////////////////////////////////////////////////////////
    // clock, then a stand-in image core that answers each flash with a frame
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        flip <= ~flip;
        frame_valid <= laser_flash;
        if (laser_flash === 1'b1) begin
            flashes <= flashes + 1;
        end
    end
    // a released line shows a changing pattern, never the last bit
    assign miso_w = (miso_oe === 1'b1) ? miso : flip;
    mss_host host (.clk(clk), .miso_w(miso_w), .pins(pins));
    mss_port #(.REST1_DOWN_TICKS(4), .REST2_DOWN_TICKS(8), .REST3_DOWN_TICKS(16)) dut (
        .clk(clk), .rst_b(rst_b), .pins(pins), .miso(miso), .miso_oe(miso_oe),
        .motion_n(motion_n), .frame(cur), .frame_valid(frame_valid),
        .laser_flash(laser_flash), .power_mode(power_mode), .loc_addr(loc_addr),
        .loc_wdata(loc_wdata), .loc_wr(loc_wr), .loc_rd(loc_rd), .loc_rdata(loc_rdata)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic spi_wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.sel(1'b1);
        host.xbyte({1'b1, a}, 8, x);
        host.xbyte(d, 8, x);
        host.sel(1'b0);
    endtask
    task automatic spi_rd(input logic [6:0] a, output logic [7:0] d);
        logic [7:0] x;
        host.sel(1'b1);
        host.xbyte({1'b0, a}, 8, x);
        host.xbyte(8'h00, 8, d);
        host.sel(1'b0);
        chk({7'h00, miso_oe}, 8'h00);
    endtask
    task automatic loc_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        loc_addr <= a;
        loc_wdata <= d;
        loc_wr <= 1'b1;
        @(posedge clk);
        loc_wr <= 1'b0;
    endtask
    task automatic loc_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        loc_addr <= a;
        loc_rd <= 1'b1;
        @(posedge clk);
        loc_rd <= 1'b0;
        #1 d = loc_rdata;
    endtask
    // offer a frame until the core takes it, then return to still frames
    task automatic inject(input mss_frame_t f);
        cur <= f;
        for (int i = 0; i < 3000 && frame_valid !== 1'b1; i++) begin
            @(posedge clk);
        end
        chk({7'h00, frame_valid}, 8'h01);
        @(posedge clk);
        cur <= '0;
    endtask
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog sized well beyond the expected run of about 55k cycles
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        close_out();
    end
    // main sequence
    initial begin
        rst_b <= 1'b0;
        loc_wr <= 1'b0;
        loc_rd <= 1'b0;
        loc_addr <= 4'h0;
        loc_wdata <= 8'h00;
        cur <= '0;
        repeat (10) @(posedge clk);
        chk({miso_oe, motion_n, laser_flash, power_mode, loc_rdata[2:0]}, 8'h40);
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        loc_read(MSS_L_CTRL, r);
        chk(r & 8'h01, 8'h01);
        loc_read(4'hF, r);
        chk(r, 8'h00);
        loc_write(MSS_L_CTRL, 8'h00);  // keep run mode while the port is exercised
        $display("test reset done");
        // back-to-back writes, then read each one back
        foreach (rows[i]) spi_wr(rows[i].a, rows[i].d);
        foreach (rows[i]) begin
            spi_rd(rows[i].a, r);
            chk(r, rows[i].d);
        end
        $display("test table done");
        // partial data byte cut off by select must leave the store untouched
        host.sel(1'b1);
        host.xbyte({1'b1, rows[0].a}, 8, r);
        host.xbyte(8'h3C, 5, r);
        host.sel(1'b0);
        spi_rd(rows[0].a, r);
        chk(r, rows[0].d);
        $display("test abort done");
        // motion pin stays low until both deltas are read
        inject({8'h05, 8'hFD, 32'h0});
        repeat (4) @(posedge clk);
        chk({7'h00, motion_n}, 8'h00);
        spi_rd(MSS_A_MOTION, r);
        chk(r & 8'h80, 8'h80);
        spi_rd(MSS_A_DX, r);
        chk(r, 8'h05);
        chk({7'h00, motion_n}, 8'h00);
        spi_rd(MSS_A_DY, r);
        chk(r, 8'hFD);
        chk({7'h00, motion_n}, 8'h01);
        inject({8'h01, 40'h0});
        spi_wr(MSS_A_MOTION, 8'h00);
        chk({7'h00, motion_n}, 8'h01);
        // the motion write drops the flag but the delta stays until read
        spi_rd(MSS_A_DX, r);
        chk(r, 8'h01);
        $display("test motion done");
        // burst returns seven bytes and locks the port until select rises
        inject({8'h11, 8'h22, 8'h33, 16'h4455, 8'h66});
        host.sel(1'b1);
        host.xbyte({1'b0, MSS_A_BURST}, 8, r);
        for (int k = 0; k < 7; k++) begin
            host.xbyte(8'h00, 8, r);
            chk(k == 0 ? r & 8'h80 : r, bexp[k]);
        end
        loc_read(MSS_L_STATUS, r);
        chk(r & 8'h04, 8'h04);
        host.sel(1'b0);
        loc_read(MSS_L_STATUS, r);
        chk(r & 8'h04, 8'h00);
        chk({7'h00, motion_n}, 8'h01);
        // a burst cut after the x byte leaves the port usable
        host.sel(1'b1);
        host.xbyte({1'b0, MSS_A_BURST}, 8, r);
        host.xbyte(8'h00, 8, r);
        host.xbyte(8'h00, 8, r);
        host.sel(1'b0);
        spi_rd(rows[1].a, r);
        chk(r, rows[1].d);
        $display("test burst done");
        // rest stepping counted from the last motion frame
        loc_write(MSS_L_CTRL, 8'h01);
        inject({8'h01, 40'h0});
        f0 = flashes;
        repeat (3 * TK) @(posedge clk);
        chk(8'(flashes - f0 >= 2 && flashes - f0 <= 4), 8'h01);
        repeat (3 * TK) @(posedge clk);
        chk({6'h00, power_mode}, {6'h00, MSS_REST1});
        repeat (6 * TK) @(posedge clk);
        chk({6'h00, power_mode}, {6'h00, MSS_REST2});
        f0 = flashes;
        repeat (6 * TK) @(posedge clk);
        chk({6'h00, power_mode}, {6'h00, MSS_REST3});
        chk(8'(flashes - f0 <= 1), 8'h01);
        loc_read(MSS_L_STATUS, r);
        chk(r & 8'h03, 8'h03);
        $display("test power done");
        close_out();
    end
endmodule
`default_nettype wire
